// [logic/sci_exec.sv]
// Purpose: executes privileged system-control, io and physical memory instructions
// Assumes: one clock, sync active-high reset, instructions issued by apb write
// Notes: io and memory transfers use one shared request/ack port
module sci_exec (
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // external bus (io or physical memory)
    output logic O_XFER_REQ,
    output logic O_XFER_IO,
    output logic O_XFER_WRITE,
    output logic [23:0] O_XFER_ADDR,
    output logic [15:0] O_XFER_WDATA,
    input wire logic I_XFER_ACK,
    input wire logic [15:0] I_XFER_RDATA,
    // mode outputs
    output logic O_PAGING_ON,
    output logic O_INTERRUPT_ON,
    output logic O_WIDE_ADDR,
    output logic O_OPERATOR_LAMP,
    output logic O_HALTED
);
    import sci_pkg::*;

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    sci_state_t state_r;
    logic irq_on_r;
    logic paging_on_r;
    logic priv_r;
    logic operator_comm_mode_r;
    logic [15:0] sts_r;
    logic [15:0] enable_r;
    logic [15:0] request_r;
    logic [3:0] level_r;
    logic [15:0] treg_r [16];
    logic [15:0] areg_r;
    logic [15:0] dreg_r;
    logic [15:0] pc_r;
    logic [15:0] instr_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic [15:0] rdata_s1_r;
    logic [15:0] rdata_s2_r;

    logic access;
    logic wr_acc;
    logic instr_wr;
    logic [15:0] ins;
    logic is_priv_op;
    logic is_wait;
    logic is_super;
    logic is_io;
    logic [3:0] top_level;
    logic [15:0] req_after_wait;
    logic [3:0] wait_level;
    logic bad_priv;
    logic [31:0] rdata_nxt;
    logic unmapped;

    assign access = I_PSEL && I_PENABLE;
    assign wr_acc = access && I_PWRITE && O_PREADY;
    assign ins = I_PWDATA[15:0];
    assign instr_wr = wr_acc && (I_PADDR == ADDR_INSTR);
    // the 8-bit operand is always below octal 400 and is never decoded
    assign is_wait = (ins[15:8] == OP_WAIT_HI);
    assign is_super = (ins[15:8] == OP_SUPERVISOR_HI);
    assign is_io = (ins[15:11] == OP_IO_EXECUTE_HI);
    assign is_priv_op = is_wait || is_io
        || ins == OP_PAGING_INTERRUPTS_OFF || ins == OP_SET_WIDE || ins == OP_CLEAR_WIDE
        || ins == OP_OPERATOR_COMM || ins == OP_IO_EXECUTE_WIDE
        || ins == OP_READ_PHYS || ins == OP_WRITE_PHYS;
    assign bad_priv = instr_wr && is_priv_op && !priv_r;

    // highest level set in both enable and request
    function automatic logic [3:0] highest(input logic [15:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 16; i++)
        begin
            if (v[i])
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    assign top_level = highest(enable_r & request_r);
    assign req_after_wait = request_r & ~(16'h0001 << level_r);
    assign wait_level = highest(enable_r & req_after_wait);

    // --------------------------------------------------------------
    // apb
    // --------------------------------------------------------------
    // busy while a transfer is in flight and until the peripheral drops ack:
    // a stale ack must not end the next transfer, and a stalled read resamples T
    assign O_PREADY = (state_r != SCI_BUS) && !ack_s2_r;
    assign unmapped = !(I_PADDR inside {ADDR_INSTR, ADDR_CTRL, ADDR_STATUS, ADDR_LEVEL, ADDR_ENABLE,
        ADDR_REQUEST, ADDR_TREG, ADDR_AREG, ADDR_DREG, ADDR_CONSOLE, ADDR_PC}) || I_PADDR[1:0] != 2'b00;
    assign O_PSLVERR = access && O_PREADY && unmapped;

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (I_PADDR == ADDR_CTRL)
        begin
            rdata_nxt = {29'h0, priv_r, paging_on_r, irq_on_r};
        end
        else if (I_PADDR == ADDR_STATUS)
        begin
            rdata_nxt = {16'h0, sts_r};
        end
        else if (I_PADDR == ADDR_LEVEL)
        begin
            rdata_nxt = {26'h0, operator_comm_mode_r, state_r == SCI_HALT, level_r};
        end
        else if (I_PADDR == ADDR_ENABLE)
        begin
            rdata_nxt = {16'h0, enable_r};
        end
        else if (I_PADDR == ADDR_REQUEST)
        begin
            rdata_nxt = {16'h0, request_r};
        end
        else if (I_PADDR == ADDR_TREG)
        begin
            rdata_nxt = {16'h0, treg_r[level_r]};
        end
        else if (I_PADDR == ADDR_AREG)
        begin
            rdata_nxt = {16'h0, areg_r};
        end
        else if (I_PADDR == ADDR_DREG)
        begin
            rdata_nxt = {16'h0, dreg_r};
        end
        else if (I_PADDR == ADDR_PC)
        begin
            rdata_nxt = {16'h0, pc_r};
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_SYS_RST)
        begin
            O_PRDATA <= 32'h0000_0000;
        end
        else if (I_PSEL && !(I_PENABLE && O_PREADY))
        begin
            // keep sampling through wait states so a stalled read returns fresh data
            O_PRDATA <= rdata_nxt;
        end
    end

    // --------------------------------------------------------------
    // ack synchroniser (peripheral side is asynchronous)
    // --------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_SYS_RST)
        begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            rdata_s1_r <= 16'h0000;
            rdata_s2_r <= 16'h0000;
        end
        else
        begin
            ack_s1_r <= I_XFER_ACK;
            ack_s2_r <= ack_s1_r;
            rdata_s1_r <= I_XFER_RDATA;
            rdata_s2_r <= rdata_s1_r;
        end
    end

    // --------------------------------------------------------------
    // sequencer and external transfer
    // --------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_SYS_RST)
        begin
            state_r <= SCI_IDLE;
            O_XFER_REQ <= 1'b0;
            O_XFER_IO <= 1'b0;
            O_XFER_WRITE <= 1'b0;
            O_XFER_ADDR <= 24'h00_0000;
            O_XFER_WDATA <= 16'h0000;
            instr_r <= 16'h0000;
        end
        else
        begin
            case (state_r)
                SCI_IDLE:
                begin
                    if (instr_wr && !bad_priv)
                    begin
                        instr_r <= ins;
                        if (is_io)
                        begin
                            state_r <= SCI_BUS;
                            O_XFER_REQ <= 1'b1;
                            O_XFER_IO <= 1'b1;
                            O_XFER_WRITE <= 1'b0;
                            O_XFER_ADDR <= {13'h0, ins[10:0]};
                            O_XFER_WDATA <= areg_r;
                        end
                        else if (ins == OP_IO_EXECUTE_WIDE)
                        begin
                            state_r <= SCI_BUS;
                            O_XFER_REQ <= 1'b1;
                            O_XFER_IO <= 1'b1;
                            O_XFER_WRITE <= 1'b0;
                            O_XFER_ADDR <= {8'h00, treg_r[level_r]};
                            O_XFER_WDATA <= areg_r;
                        end
                        else if (ins == OP_READ_PHYS || ins == OP_WRITE_PHYS)
                        begin
                            state_r <= SCI_BUS;
                            O_XFER_REQ <= 1'b1;
                            O_XFER_IO <= 1'b0;
                            O_XFER_WRITE <= (ins == OP_WRITE_PHYS);
                            O_XFER_ADDR <= {areg_r[7:0], dreg_r};
                            O_XFER_WDATA <= treg_r[level_r];
                        end
                        else if (is_wait && !irq_on_r)
                        begin
                            state_r <= SCI_HALT;
                        end
                    end
                end
                SCI_BUS:
                begin
                    // peripheral must drop ack before the next transfer
                    if (ack_s2_r)
                    begin
                        O_XFER_REQ <= 1'b0;
                        state_r <= SCI_IDLE;
                    end
                end
                SCI_HALT:
                begin
                    if (wr_acc && I_PADDR == ADDR_CONSOLE && I_PWDATA[7:0] == CHAR_RESUME)
                    begin
                        state_r <= SCI_IDLE;
                    end
                end
                default:
                begin
                    state_r <= SCI_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // mode bits and status
    // --------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_SYS_RST)
        begin
            {priv_r, paging_on_r, irq_on_r} <= RST_CTRL;
            sts_r <= RST_STATUS;
            operator_comm_mode_r <= 1'b0;
        end
        else if (wr_acc && I_PADDR == ADDR_CTRL)
        begin
            {priv_r, paging_on_r, irq_on_r} <= I_PWDATA[2:0];
        end
        else if (wr_acc && I_PADDR == ADDR_STATUS)
        begin
            sts_r <= I_PWDATA[15:0];
        end
        else if (instr_wr && !bad_priv && state_r == SCI_IDLE)
        begin
            if (ins == OP_PAGING_INTERRUPTS_OFF)
            begin
                paging_on_r <= 1'b0;
                irq_on_r <= 1'b0;
            end
            else if (ins == OP_SET_WIDE)
            begin
                sts_r[STS_WIDE_BIT] <= 1'b1;
            end
            else if (ins == OP_CLEAR_WIDE)
            begin
                sts_r[STS_WIDE_BIT] <= 1'b0;
            end
            else if (ins == OP_OPERATOR_COMM)
            begin
                operator_comm_mode_r <= 1'b1;
            end
        end
        else if (wr_acc && I_PADDR == ADDR_CONSOLE && I_PWDATA[7:0] == CHAR_RESUME)
        begin
            operator_comm_mode_r <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // levels, pc and working registers
    // --------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_SYS_RST)
        begin
            enable_r <= RST_ENABLE;
            request_r <= RST_REQUEST;
            level_r <= 4'h0;
            areg_r <= 16'h0000;
            dreg_r <= 16'h0000;
            pc_r <= 16'h0000;
            for (int i = 0; i < 16; i++)
            begin
                treg_r[i] <= 16'h0000;
            end
        end
        else
        begin
            if (instr_wr && state_r == SCI_IDLE)
            begin
                pc_r <= pc_r + 16'h0001;
            end
            if (wr_acc && I_PADDR == ADDR_ENABLE)
            begin
                enable_r <= I_PWDATA[15:0];
            end
            else if (wr_acc && I_PADDR == ADDR_REQUEST)
            begin
                request_r <= I_PWDATA[15:0];
            end
            else if (bad_priv)
            begin
                request_r[LEVEL_SUPERVISOR] <= 1'b1;
            end
            else if (instr_wr && state_r == SCI_IDLE && is_super)
            begin
                request_r[LEVEL_SUPERVISOR] <= 1'b1;
                treg_r[LEVEL_SUPERVISOR] <= {{8{ins[7]}}, ins[7:0]};
            end
            else if (instr_wr && state_r == SCI_IDLE && is_wait && irq_on_r && level_r != 4'h0)
            begin
                request_r <= req_after_wait;
                level_r <= wait_level;
            end
            else if (irq_on_r)
            begin
                level_r <= top_level;
            end
            if (wr_acc && I_PADDR == ADDR_AREG)
            begin
                areg_r <= I_PWDATA[15:0];
            end
            if (wr_acc && I_PADDR == ADDR_DREG)
            begin
                dreg_r <= I_PWDATA[15:0];
            end
            if (wr_acc && I_PADDR == ADDR_TREG)
            begin
                treg_r[level_r] <= I_PWDATA[15:0];
            end
            else if (state_r == SCI_BUS && ack_s2_r && !O_XFER_WRITE)
            begin
                treg_r[level_r] <= rdata_s2_r;
            end
        end
    end

    assign O_PAGING_ON = paging_on_r;
    assign O_INTERRUPT_ON = irq_on_r;
    assign O_WIDE_ADDR = sts_r[STS_WIDE_BIT];
    assign O_OPERATOR_LAMP = operator_comm_mode_r || (state_r == SCI_HALT);
    assign O_HALTED = (state_r == SCI_HALT);
endmodule

// [logic/sci_pkg.sv]
// Purpose: constants for the system-control instruction executer
// Assumes: 16-bit instruction words, octal opcodes
// Notes: registers reached over apb; offsets below are byte addresses
//
// Contract
// - combined-off opcode turns off paging and interrupt system together
// - set-wide-addressing switches paging to 24-bit physical addresses
// - set-wide-addressing also sets status bit 13
// - clear-wide-addressing returns paging to 19-bit physical addresses
// - clear-wide-addressing clears status bit 13
// - operator-communication opcode enters operator mode like the panel button
// - wait with interrupts off halts, program counter past the wait
// - programmed wait lights operator lamp; console '!' resumes
// - wait with interrupts on clears own request bit, gives up priority
// - no pending request enters level zero; wait on level zero is no-op
// - wait operand below octal 400 does not alter behaviour
// - supervisor call interrupts to level 14, 8-bit call number
// - supervisor call operand sign-extended into level 14 T register
// - io execute uses low 11 instruction bits as device register address
// - wide io execute uses full 16-bit T as device address
// - read-physical-word loads T from physical address A:D
// - write-physical-word stores T to physical address A:D
// - all above except supervisor call need privileged state
// - with switching on, run highest level set in enable and request
package sci_pkg;
    localparam logic [15:0] OP_PAGING_INTERRUPTS_OFF = 16'hD105; // 150405 octal
    localparam logic [15:0] OP_OPERATOR_COMM = 16'hD100;         // 150400
    localparam logic [15:0] OP_SET_WIDE = 16'hD106;              // 150406
    localparam logic [15:0] OP_CLEAR_WIDE = 16'hD107;            // 150407
    localparam logic [15:0] OP_IO_EXECUTE_WIDE = 16'hD10D;       // 150415
    localparam logic [15:0] OP_READ_PHYS = 16'hD10E;             // 150416
    localparam logic [15:0] OP_WRITE_PHYS = 16'hD10F;            // 150417
    localparam logic [7:0] OP_WAIT_HI = 8'hD2;                   // 151xxx
    localparam logic [7:0] OP_SUPERVISOR_HI = 8'hD6;             // 153xxx
    localparam logic [4:0] OP_IO_EXECUTE_HI = 5'h1D;             // 164000 bits 15:11
    localparam int STS_WIDE_BIT = 13;
    localparam logic [3:0] LEVEL_SUPERVISOR = 4'hE;
    localparam logic [7:0] CHAR_RESUME = 8'h21;
    // apb map (byte addresses)
    localparam logic [7:0] ADDR_INSTR = 8'h00;   // write: issue instruction
    localparam logic [7:0] ADDR_CTRL = 8'h04;    // bit0 interrupt on, bit1 paging on, bit2 privileged
    localparam logic [7:0] ADDR_STATUS = 8'h08;  // status register
    localparam logic [7:0] ADDR_LEVEL = 8'h0C;   // current level, halt, operator mode
    localparam logic [7:0] ADDR_ENABLE = 8'h10;  // level_enable_bits
    localparam logic [7:0] ADDR_REQUEST = 8'h14; // level_request_bits
    localparam logic [7:0] ADDR_TREG = 8'h18;    // T register of current level
    localparam logic [7:0] ADDR_AREG = 8'h1C;
    localparam logic [7:0] ADDR_DREG = 8'h20;
    localparam logic [7:0] ADDR_CONSOLE = 8'h24; // write: console character
    localparam logic [7:0] ADDR_PC = 8'h28;
    localparam logic [15:0] RST_STATUS = 16'h0000;
    localparam logic [15:0] RST_ENABLE = 16'h0000;
    localparam logic [15:0] RST_REQUEST = 16'h0000;
    localparam logic [2:0] RST_CTRL = 3'h4;
    typedef enum logic [1:0] {
        SCI_IDLE = 2'b00,
        SCI_BUS = 2'b01,
        SCI_HALT = 2'b10
    } sci_state_t;
endpackage

// [testbench/sci_exec_checker.sv]
// Purpose: port-level checks for sci_exec
// Assumes: privileged state follows the last ctrl write
// Notes: accepted instruction writes outside a halt start every check except the halt-lamp one
module sci_exec_checker
    import sci_pkg::*;
(
    // watched ports
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic O_PREADY,
    input wire logic O_XFER_REQ,
    input wire logic O_XFER_IO,
    input wire logic O_XFER_WRITE,
    input wire logic [23:0] O_XFER_ADDR,
    input wire logic O_PAGING_ON,
    input wire logic O_INTERRUPT_ON,
    input wire logic O_WIDE_ADDR,
    input wire logic O_OPERATOR_LAMP,
    input wire logic O_HALTED
);
    timeunit 1ns;
    timeprecision 100ps;
    logic priv_r;
    logic [15:0] wd_r;
    wire logic wr = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
    wire logic ins = wr && I_PADDR == ADDR_INSTR && !O_HALTED;
    wire logic pv = ins && priv_r;
    wire logic [15:0] op = I_PWDATA[15:0];
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_SYS_RST)
            priv_r <= RST_CTRL[2];
        else if (wr && I_PADDR == ADDR_CTRL)
            priv_r <= I_PWDATA[2];
    end
    // io address is checked after the write, so keep the word
    always_ff @(posedge I_SYS_CLK)
    begin
        if (wr)
            wd_r <= I_PWDATA[15:0];
    end
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);
    // ----
    // properties
    // ----
    property p_set_wide;
        pv && op == OP_SET_WIDE |=> O_WIDE_ADDR;
    endproperty
    a_set_wide: assert property (p_set_wide) else $error("wide mode not set");
    property p_clear_wide;
        pv && op == OP_CLEAR_WIDE |=> !O_WIDE_ADDR;
    endproperty
    a_clear_wide: assert property (p_clear_wide) else $error("wide mode not cleared");
    property p_both_off;
        pv && op == OP_PAGING_INTERRUPTS_OFF |=> !O_PAGING_ON && !O_INTERRUPT_ON;
    endproperty
    a_both_off: assert property (p_both_off) else $error("paging or interrupts still on");
    property p_operator_comm_mode;
        pv && op == OP_OPERATOR_COMM |=> O_OPERATOR_LAMP;
    endproperty
    a_operator_comm_mode: assert property (p_operator_comm_mode) else $error("operator mode not entered");
    property p_wait_halt;
        pv && op[15:8] == OP_WAIT_HI && !O_INTERRUPT_ON |=> O_HALTED;
    endproperty
    a_wait_halt: assert property (p_wait_halt) else $error("wait did not halt");
    property p_halt_lamp;
        O_HALTED |-> O_OPERATOR_LAMP;
    endproperty
    a_halt_lamp: assert property (p_halt_lamp) else $error("lamp dark in halt");
    property p_io_req;
        pv && op[15:11] == OP_IO_EXECUTE_HI |-> ##[1:3]
            (O_XFER_REQ && O_XFER_IO && !O_XFER_WRITE && O_XFER_ADDR == {13'h0000, wd_r[10:0]});
    endproperty
    a_io_req: assert property (p_io_req) else $error("io transfer wrong");
    property p_wr_phys;
        pv && op == OP_WRITE_PHYS |-> ##[1:3] (O_XFER_REQ && O_XFER_WRITE && !O_XFER_IO);
    endproperty
    a_wr_phys: assert property (p_wr_phys) else $error("memory write missing");
    property p_unpriv;
        ins && !priv_r && op == OP_SET_WIDE |=> $stable(O_WIDE_ADDR);
    endproperty
    a_unpriv: assert property (p_unpriv) else $error("unprivileged op took effect");
    c_io: cover property (O_XFER_REQ && O_XFER_IO);
    c_halt: cover property (O_HALTED);
    c_stall: cover property (!O_PREADY);
endmodule

bind sci_exec sci_exec_checker u_sci_exec_checker (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PREADY(O_PREADY), .O_XFER_REQ(O_XFER_REQ), .O_XFER_IO(O_XFER_IO), .O_XFER_WRITE(O_XFER_WRITE),
    .O_XFER_ADDR(O_XFER_ADDR), .O_PAGING_ON(O_PAGING_ON), .O_INTERRUPT_ON(O_INTERRUPT_ON),
    .O_WIDE_ADDR(O_WIDE_ADDR), .O_OPERATOR_LAMP(O_OPERATOR_LAMP), .O_HALTED(O_HALTED));

// [testbench/sci_xfer_model.sv]
// Purpose: io devices and physical memory behind the transfer port
// Assumes: four-phase request and acknowledge
// Notes: data line shows inverted last word once ack drops
module sci_xfer_model (
    // transfer port
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_io,
    input wire logic i_write,
    input wire logic [23:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [3:0] i_delay,
    output logic o_ack,
    output logic [15:0] o_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [0:255];
    logic [23:0] last_addr;
    int cnt;
    initial
    begin
        o_ack = 1'b0;
        o_rdata = 16'h0000;
        cnt = 0;
    end
    // ----
    // answer
    // ----
    always @(posedge i_clk)
    begin
        if (i_req && !o_ack)
        begin
            cnt <= cnt + 1;
            if (cnt >= i_delay)
            begin
                cnt <= 0;
                last_addr <= i_addr;
                if (i_write && !i_io)
                    mem[i_addr[7:0]] <= i_wdata;
                // each device answers a run of successive register addresses
                o_rdata <= i_io ? (i_addr[15:0] ^ 16'hA5A5) : mem[i_addr[7:0]];
                o_ack <= 1'b1;
            end
        end
        else if (!i_req && o_ack)
        begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
        end
    end
endmodule

// [testbench/testbench.sv]
// Purpose: self-checking bench for sci_exec
// Assumes: apb master waits for pready; model answers transfers
// Notes: each apb task idles one edge before its setup cycle
`define CHK(nm, ex, got) \
    n_tests++; \
    if ((got) !== (ex)) \
    begin \
        err_total++; \
        $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end
module testbench;
    import sci_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, e;
    logic req, xio, xwr, ack, paging, inton, wide, lamp, halted;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [23:0] xaddr;
    logic [15:0] xwd, xrd;
    logic [3:0] delay;
    int err_total, n_tests;
    sci_exec u_sci_exec (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_XFER_REQ(req), .O_XFER_IO(xio), .O_XFER_WRITE(xwr), .O_XFER_ADDR(xaddr),
        .O_XFER_WDATA(xwd), .I_XFER_ACK(ack), .I_XFER_RDATA(xrd), .O_PAGING_ON(paging),
        .O_INTERRUPT_ON(inton), .O_WIDE_ADDR(wide), .O_OPERATOR_LAMP(lamp), .O_HALTED(halted));
    sci_xfer_model u_sci_xfer_model (.i_clk(clk), .i_req(req), .i_io(xio), .i_write(xwr), .i_addr(xaddr),
        .i_wdata(xwd), .i_delay(delay), .o_ack(ack), .o_rdata(xrd));
    // ----
    // bus tasks
    // ----
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let the accepting edge settle before callers look at outputs
        @(negedge clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h00000000);
    endtask
    task ins(input logic [15:0] op);
        wr(ADDR_INSTR, {16'h0000, op});
    endtask
    task t_reset;
        rd(ADDR_CTRL);
        `CHK("ctrl", {29'h00000000, RST_CTRL}, q)
        rd(8'h3C);
        `CHK("slverr", 1'b1, e)
    endtask
    task t_wide;
        ins(OP_SET_WIDE);
        `CHK("wide", 1'b1, wide)
        rd(ADDR_STATUS);
        `CHK("sts", 1'b1, q[STS_WIDE_BIT])
        ins(OP_CLEAR_WIDE);
        `CHK("wide", 1'b0, wide)
        rd(ADDR_STATUS);
        `CHK("sts", 1'b0, q[STS_WIDE_BIT])
    endtask
    task t_off;
        wr(ADDR_CTRL, 32'h00000007);
        ins(OP_PAGING_INTERRUPTS_OFF);
        `CHK("onoff", 2'b00, {paging, inton})
        ins(OP_OPERATOR_COMM);
        `CHK("lamp", 1'b1, lamp)
        wr(ADDR_CONSOLE, {24'h000000, CHAR_RESUME});
    endtask
    task t_wait_off;
        logic [15:0] p;
        rd(ADDR_PC);
        p = q[15:0] + 16'h0001;
        ins({OP_WAIT_HI, 8'hFF});
        `CHK("halt", 2'b11, {halted, lamp})
        rd(ADDR_PC);
        `CHK("pc", p, q[15:0])
        ins(OP_SET_WIDE);
        `CHK("wide", 1'b0, wide)
        wr(ADDR_CONSOLE, {24'h000000, CHAR_RESUME});
        `CHK("halt", 1'b0, halted)
    endtask
    task t_wait_on;
        wr(ADDR_CTRL, 32'h00000005);
        wr(ADDR_ENABLE, 32'h00000030);
        wr(ADDR_REQUEST, 32'h00000030);
        rd(ADDR_LEVEL);
        `CHK("level", 4'h5, q[3:0])
        ins({OP_WAIT_HI, 8'h00});
        rd(ADDR_REQUEST);
        `CHK("request", 32'h00000010, q)
        rd(ADDR_LEVEL);
        `CHK("level", 4'h4, q[3:0])
        repeat (2) ins({OP_WAIT_HI, 8'h00});
        rd(ADDR_LEVEL);
        `CHK("level", 5'h00, q[4:0])
    endtask
    task t_svc;
        wr(ADDR_ENABLE, 32'h00004000);
        wr(ADDR_CTRL, 32'h00000001);
        ins({OP_SUPERVISOR_HI, 8'h80});
        rd(ADDR_LEVEL);
        `CHK("level", LEVEL_SUPERVISOR, q[3:0])
        rd(ADDR_TREG);
        `CHK("treg", 32'h0000FF80, q)
        wr(ADDR_REQUEST, 32'h00000000);
        wr(ADDR_CTRL, 32'h00000004);
    endtask
    task t_io;
        ins({OP_IO_EXECUTE_HI, 11'h5A3});
        rd(ADDR_TREG);
        `CHK("treg", 32'h0000A006, q)
        `CHK("xaddr", 24'h0005A3, u_sci_xfer_model.last_addr)
        delay <= 4'h9;
        wr(ADDR_TREG, 32'h0000BEEF);
        ins(OP_IO_EXECUTE_WIDE);
        rd(ADDR_TREG);
        `CHK("treg", 32'h00001B4A, q)
        `CHK("xaddr", 24'h00BEEF, u_sci_xfer_model.last_addr)
        delay <= 4'h0;
    endtask
    task t_phys;
        wr(ADDR_AREG, 32'h00000012);
        wr(ADDR_DREG, 32'h00003456);
        wr(ADDR_TREG, 32'h0000CAFE);
        ins(OP_WRITE_PHYS);
        wr(ADDR_TREG, 32'h00000000);
        `CHK("xaddr", 24'h123456, u_sci_xfer_model.last_addr)
        `CHK("mem", 16'hCAFE, u_sci_xfer_model.mem[8'h56])
        ins(OP_READ_PHYS);
        rd(ADDR_TREG);
        `CHK("treg", 32'h0000CAFE, q)
    endtask
    task t_unpriv;
        wr(ADDR_CTRL, 32'h00000000);
        ins(OP_SET_WIDE);
        `CHK("wide", 1'b0, wide)
        rd(ADDR_REQUEST);
        `CHK("req14", 1'b1, q[14])
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        delay = 4'h0;
        err_total = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_wide;
        t_off;
        t_wait_off;
        t_wait_on;
        t_svc;
        t_io;
        t_phys;
        t_unpriv;
        wrap_up;
    end
    // whole run needs far fewer cycles than this
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        wrap_up;
    end
endmodule
